// file: iwc_pkg.sv
// Constants shared by the two-wire wait, acknowledge and interrupt control
// ----------------------------------------------------------------------------
// How it works
// - Writing one to wait release ends the wait; the bit then self-clears.
// - Release at ninth clock while transmitting frees data line, clears transmit flag.
// - Disabling clears bus status, start-fail, busy, clock and data level bits.
// - With unit disabled, release, stop irq, wait point and ack bits do nothing.
// - Enabling while clock high and data low detects a start at once.
// - Stop detection raises an interrupt only while stop irq enable is one.
// - Wait point zero: interrupt at eighth falling edge; master holds clock, waits.
// - Wait point zero as slave: clock held low after eight received clocks.
// - Wait point one: interrupt and wait at ninth falling edge, master or slave.
// - Address transfers always interrupt at ninth falling edge; wait point applies after.
// - Master always waits at ninth falling edge of an address transfer.
// - Slave with own address matched waits at ninth falling edge after acking.
// - Slave that received an extension code waits at eighth falling edge.
// - Ack enable one drives data low throughout the ninth clock; zero never acks a data byte.
// - Ack enable does not govern the acknowledge of address transfers.
// - Reset clears the whole control register to zero.
// - Enable zero stops operation and resets status; enable one runs.
// ----------------------------------------------------------------------------
package iwc_pkg;

  // --------------------------------------------------------------------------
  // Register offsets
  // --------------------------------------------------------------------------
  localparam logic [7:0] IWC_OFF_CTRL   = 8'h00;
  localparam logic [7:0] IWC_OFF_STATUS = 8'h04;

  // --------------------------------------------------------------------------
  // Control register fields and reset value
  // --------------------------------------------------------------------------
  localparam int         IWC_CTRL_EN    = 7;
  localparam int         IWC_CTRL_LREL  = 6;
  localparam int         IWC_CTRL_WREL  = 5;
  localparam int         IWC_CTRL_SPIE  = 4;
  localparam int         IWC_CTRL_WTIM  = 3;
  localparam int         IWC_CTRL_ACKE  = 2;
  localparam logic [7:0] IWC_CTRL_RESET = 8'h00;

  // --------------------------------------------------------------------------
  // Status register fields
  // --------------------------------------------------------------------------
  localparam int IWC_ST_TRC  = 0;
  localparam int IWC_ST_WAIT = 1;
  localparam int IWC_ST_ADDR = 2;
  localparam int IWC_ST_BUSY = 3;
  localparam int IWC_ST_FAIL = 4;
  localparam int IWC_ST_CLD  = 5;
  localparam int IWC_ST_DAD  = 6;
  localparam int IWC_ST_CNT  = 8;

  // --------------------------------------------------------------------------
  // Clock counts within a byte
  // --------------------------------------------------------------------------
  localparam logic [3:0] IWC_CNT_IDLE   = 4'h0;
  localparam logic [3:0] IWC_CNT_FIRST  = 4'h1;
  localparam logic [3:0] IWC_CNT_EIGHTH = 4'h8;
  localparam logic [3:0] IWC_CNT_NINTH  = 4'h9;

  // Idle level of both bus lines, used as synchroniser reset
  localparam logic IWC_LINE_IDLE = 1'b1;

endpackage

// file: iwc_sync.sv
// Two-stage synchroniser for one bus line
`timescale 1ns/100ps
module iwc_sync
  import iwc_pkg::*;
(
  // Clock and reset
  input  wire logic clk,
  input  wire logic rstn,
  // Line in and synchronised level out
  input  wire logic din,
  output logic      dout
);

  logic meta_ff;
  logic nxt_meta;
  logic nxt_dout;

  // Next values of both stages
  always_comb begin
    nxt_meta = din;
    nxt_dout = meta_ff;
  end

  // Stage registers, first stage read only by second
  always_ff @(posedge clk) begin
    if (!rstn) begin
      meta_ff <= IWC_LINE_IDLE;
      dout    <= IWC_LINE_IDLE;
    end else begin
      meta_ff <= nxt_meta;
      dout    <= nxt_dout;
    end
  end

endmodule

// file: iwc_cond.sv
// Clock edge and start/stop condition detector on synchronised lines
`timescale 1ns/100ps
module iwc_cond
  import iwc_pkg::*;
(
  // Clock and reset
  input  wire logic clk,
  input  wire logic rstn,
  // Synchronised line levels
  input  wire logic scl_s,
  input  wire logic sda_s,
  // Detected events, one-cycle pulses
  output logic      scl_fall,
  output logic      start_det,
  output logic      stop_det
);

  logic scl_d_ff;
  logic sda_d_ff;
  logic nxt_scl_d;
  logic nxt_sda_d;

  // Delayed copies for edge finding
  always_comb begin
    nxt_scl_d = scl_s;
    nxt_sda_d = sda_s;
  end

  always_ff @(posedge clk) begin
    if (!rstn) begin
      scl_d_ff <= IWC_LINE_IDLE;
      sda_d_ff <= IWC_LINE_IDLE;
    end else begin
      scl_d_ff <= nxt_scl_d;
      sda_d_ff <= nxt_sda_d;
    end
  end

  // Data moving while clock stays high marks start or stop
  assign scl_fall  = scl_d_ff & ~scl_s;
  assign start_det = scl_d_ff & scl_s & sda_d_ff & ~sda_s;
  assign stop_det  = scl_d_ff & scl_s & ~sda_d_ff & sda_s;

endmodule

// file: iwc_top.sv
// Wait point, acknowledge and interrupt control with its AHB-Lite register slave
`timescale 1ns/100ps
module iwc_top
  import iwc_pkg::*;
(
  // Clock and reset
  input  wire logic        clk,
  input  wire logic        rstn,
  // AHB-Lite slave
  input  wire logic        hsel,
  input  wire logic [31:0] haddr,
  input  wire logic [1:0]  htrans,
  input  wire logic        hwrite,
  input  wire logic [2:0]  hsize,
  input  wire logic [31:0] hwdata,
  input  wire logic        hready,
  output logic [31:0]      hrdata,
  output logic             hreadyout,
  output logic             hresp,
  // Serial clock pin
  input  wire logic        serial_clock_pin_in,
  output logic             serial_clock_pin_out,
  output logic             serial_clock_pin_oe,
  // Serial data pin
  input  wire logic        serial_data_pin_in,
  output logic             serial_data_pin_out,
  output logic             serial_data_pin_oe,
  // From neighbouring transfer logic
  input  wire logic        role_master,
  input  wire logic        addr_match,
  input  wire logic        ext_code,
  input  wire logic        tx_dir,
  input  wire logic        tx_low,
  input  wire logic        restart_req,
  input  wire logic        start_fail_evt,
  // To the system
  output logic             irq_req,
  output logic             unit_enable
);

  // --------------------------------------------------------------------------
  // Line synchronisers and condition detector
  // --------------------------------------------------------------------------
  logic scl_s;
  logic sda_s;
  logic scl_fall;
  logic cond_start;
  logic stop_det;

  iwc_sync u_sync_scl (
    .clk  (clk),
    .rstn (rstn),
    .din  (serial_clock_pin_in),
    .dout (scl_s)
  );

  iwc_sync u_sync_sda (
    .clk  (clk),
    .rstn (rstn),
    .din  (serial_data_pin_in),
    .dout (sda_s)
  );

  iwc_cond u_cond (
    .clk       (clk),
    .rstn      (rstn),
    .scl_s     (scl_s),
    .sda_s     (sda_s),
    .scl_fall  (scl_fall),
    .start_det (cond_start),
    .stop_det  (stop_det)
  );

  // --------------------------------------------------------------------------
  // AHB-Lite slave
  // --------------------------------------------------------------------------
  logic        wr_ph_ff;
  logic        rd_ph_ff;
  logic [7:0]  addr_ff;
  logic [31:0] rdata_ff;
  logic        nxt_wr_ph;
  logic        nxt_rd_ph;
  logic [7:0]  nxt_addr;
  logic [31:0] nxt_rdata;
  logic        accept;
  logic        wr_ctrl;
  logic [31:0] status_word;
  logic [7:0]  ctrl_word;

  assign accept    = hsel & htrans[1] & hready;
  assign wr_ctrl   = wr_ph_ff & (addr_ff == IWC_OFF_CTRL);
  assign hreadyout = ~rd_ph_ff;
  assign hresp     = 1'b0;
  assign hrdata    = rdata_ff;

  // Phase tracking; reads take one wait state to register data
  always_comb begin
    nxt_wr_ph = accept & hwrite;
    nxt_rd_ph = accept & ~hwrite;
    nxt_addr  = accept ? haddr[7:0] : addr_ff;
    nxt_rdata = rdata_ff;
    if (rd_ph_ff) begin
      unique case (addr_ff)
        IWC_OFF_CTRL:   nxt_rdata = {24'h000000, ctrl_word};
        IWC_OFF_STATUS: nxt_rdata = status_word;
        default:        nxt_rdata = 32'h00000000;
      endcase
    end
  end

  always_ff @(posedge clk) begin
    if (!rstn) begin
      wr_ph_ff <= 1'b0;
      rd_ph_ff <= 1'b0;
      addr_ff  <= 8'h00;
      rdata_ff <= 32'h00000000;
    end else begin
      wr_ph_ff <= nxt_wr_ph;
      rd_ph_ff <= nxt_rd_ph;
      addr_ff  <= nxt_addr;
      rdata_ff <= nxt_rdata;
    end
  end

  // --------------------------------------------------------------------------
  // Control register
  // --------------------------------------------------------------------------
  logic en_ff;
  logic lrel_ff;
  logic wrel_ff;
  logic spie_ff;
  logic wtim_ff;
  logic acke_ff;
  logic nxt_en;
  logic nxt_lrel;
  logic nxt_wrel;
  logic nxt_spie;
  logic nxt_wtim;
  logic nxt_acke;

  assign ctrl_word = {en_ff, lrel_ff, wrel_ff, spie_ff, wtim_ff, acke_ff, 2'b00};
  assign unit_enable = en_ff;

  // Software writes; release and exit bits clear themselves
  always_comb begin
    nxt_en   = en_ff;
    nxt_spie = spie_ff;
    nxt_wtim = wtim_ff;
    nxt_acke = acke_ff;
    nxt_lrel = 1'b0;
    nxt_wrel = 1'b0;
    if (wr_ctrl) begin
      nxt_en   = hwdata[IWC_CTRL_EN];
      nxt_spie = hwdata[IWC_CTRL_SPIE];
      nxt_wtim = hwdata[IWC_CTRL_WTIM];
      nxt_acke = hwdata[IWC_CTRL_ACKE];
      nxt_lrel = hwdata[IWC_CTRL_LREL] & hwdata[IWC_CTRL_EN];
      nxt_wrel = hwdata[IWC_CTRL_WREL] & hwdata[IWC_CTRL_EN];
    end
  end

  always_ff @(posedge clk) begin
    if (!rstn) begin
      en_ff   <= IWC_CTRL_RESET[IWC_CTRL_EN];
      lrel_ff <= IWC_CTRL_RESET[IWC_CTRL_LREL];
      wrel_ff <= IWC_CTRL_RESET[IWC_CTRL_WREL];
      spie_ff <= IWC_CTRL_RESET[IWC_CTRL_SPIE];
      wtim_ff <= IWC_CTRL_RESET[IWC_CTRL_WTIM];
      acke_ff <= IWC_CTRL_RESET[IWC_CTRL_ACKE];
    end else begin
      en_ff   <= nxt_en;
      lrel_ff <= nxt_lrel;
      wrel_ff <= nxt_wrel;
      spie_ff <= nxt_spie;
      wtim_ff <= nxt_wtim;
      acke_ff <= nxt_acke;
    end
  end

  // --------------------------------------------------------------------------
  // Link state: byte count, waits, acknowledge and interrupt
  // --------------------------------------------------------------------------
  logic       en_d_ff;
  logic [3:0] cnt_ff;
  logic       wait_ff;
  logic       adr_ff;
  logic       trc_ff;
  logic       busy_ff;
  logic       fail_ff;
  logic       cld_ff;
  logic       dad_ff;
  logic       irq_ff;
  logic       sda_oe_ff;
  logic [3:0] nxt_cnt;
  logic       nxt_wait;
  logic       nxt_adr;
  logic       nxt_trc;
  logic       nxt_busy;
  logic       nxt_fail;
  logic       nxt_cld;
  logic       nxt_dad;
  logic       nxt_irq;
  logic       nxt_sda_oe;
  logic [3:0] fall_cnt;
  logic       start_det;
  logic       at8_wait;
  logic       at8_irq;
  logic       at9_wait;
  logic       at9_irq;
  logic       ack_now;

  // Enabling on a held-low data line counts as a start
  assign start_det = cond_start | (en_ff & ~en_d_ff & scl_s & ~sda_s);
  assign fall_cnt  = (cnt_ff == IWC_CNT_NINTH) ? IWC_CNT_FIRST : cnt_ff + 4'h1;

  // Where the byte stalls and interrupts
  assign at8_irq  = ~adr_ff & ~wtim_ff;
  assign at8_wait = adr_ff ? (ext_code & ~role_master) : ~wtim_ff;
  assign at9_irq  = adr_ff | wtim_ff;
  assign at9_wait = adr_ff ? (role_master | addr_match) : wtim_ff;

  // Low data line through the ninth clock of a received byte
  assign ack_now = (cnt_ff == IWC_CNT_EIGHTH) & ~trc_ff &
                   (adr_ff ? (addr_match & ~role_master) : acke_ff);

  always_comb begin
    nxt_cnt    = cnt_ff;
    nxt_wait   = wait_ff;
    nxt_adr    = adr_ff;
    nxt_trc    = trc_ff;
    nxt_busy   = busy_ff;
    nxt_fail   = fail_ff | start_fail_evt;
    nxt_cld    = scl_s;
    nxt_dad    = sda_s;
    nxt_irq    = 1'b0;
    nxt_sda_oe = ack_now | (trc_ff & tx_low & (cnt_ff < IWC_CNT_EIGHTH));
    if (!en_ff) begin
      // Disabled unit holds all status clear and ignores control bits
      nxt_cnt    = IWC_CNT_IDLE;
      nxt_wait   = 1'b0;
      nxt_adr    = 1'b0;
      nxt_trc    = 1'b0;
      nxt_busy   = 1'b0;
      nxt_fail   = 1'b0;
      nxt_cld    = 1'b0;
      nxt_dad    = 1'b0;
      nxt_sda_oe = 1'b0;
    end else if (lrel_ff) begin
      // Leaving the transfer frees both lines
      nxt_cnt    = IWC_CNT_IDLE;
      nxt_wait   = 1'b0;
      nxt_adr    = 1'b0;
      nxt_trc    = 1'b0;
      nxt_sda_oe = 1'b0;
    end else if (start_det) begin
      nxt_busy = 1'b1;
      nxt_adr  = 1'b1;
      nxt_cnt  = IWC_CNT_IDLE;
      nxt_wait = 1'b0;
      nxt_trc  = tx_dir;
    end else if (stop_det) begin
      nxt_busy = 1'b0;
      nxt_adr  = 1'b0;
      nxt_cnt  = IWC_CNT_IDLE;
      nxt_wait = 1'b0;
      nxt_irq  = spie_ff;
    end else if (wait_ff) begin
      // Clock stays held until software or a restart lets it go
      if (wrel_ff | restart_req) begin
        nxt_wait = 1'b0;
        if (cnt_ff == IWC_CNT_NINTH) begin
          nxt_trc    = 1'b0;
          nxt_sda_oe = 1'b0;
        end
      end
    end else if (scl_fall) begin
      nxt_cnt = fall_cnt;
      if (fall_cnt == IWC_CNT_FIRST) begin
        nxt_trc = tx_dir;
      end
      if (fall_cnt == IWC_CNT_EIGHTH) begin
        nxt_irq  = at8_irq;
        nxt_wait = at8_wait;
      end
      if (fall_cnt == IWC_CNT_NINTH) begin
        nxt_irq  = at9_irq;
        nxt_wait = at9_wait;
        nxt_adr  = 1'b0;
      end
    end
  end

  always_ff @(posedge clk) begin
    if (!rstn) begin
      en_d_ff   <= 1'b0;
      cnt_ff    <= IWC_CNT_IDLE;
      wait_ff   <= 1'b0;
      adr_ff    <= 1'b0;
      trc_ff    <= 1'b0;
      busy_ff   <= 1'b0;
      fail_ff   <= 1'b0;
      cld_ff    <= 1'b0;
      dad_ff    <= 1'b0;
      irq_ff    <= 1'b0;
      sda_oe_ff <= 1'b0;
    end else begin
      en_d_ff   <= en_ff;
      cnt_ff    <= nxt_cnt;
      wait_ff   <= nxt_wait;
      adr_ff    <= nxt_adr;
      trc_ff    <= nxt_trc;
      busy_ff   <= nxt_busy;
      fail_ff   <= nxt_fail;
      cld_ff    <= nxt_cld;
      dad_ff    <= nxt_dad;
      irq_ff    <= nxt_irq;
      sda_oe_ff <= nxt_sda_oe;
    end
  end

  // --------------------------------------------------------------------------
  // Pins, interrupt and status
  // --------------------------------------------------------------------------
  assign serial_clock_pin_out = 1'b0;
  assign serial_clock_pin_oe  = wait_ff;
  assign serial_data_pin_out  = 1'b0;
  assign serial_data_pin_oe   = sda_oe_ff;
  assign irq_req              = irq_ff;

  always_comb begin
    status_word                         = 32'h00000000;
    status_word[IWC_ST_TRC]             = trc_ff;
    status_word[IWC_ST_WAIT]            = wait_ff;
    status_word[IWC_ST_ADDR]            = adr_ff;
    status_word[IWC_ST_BUSY]            = busy_ff;
    status_word[IWC_ST_FAIL]            = fail_ff;
    status_word[IWC_ST_CLD]             = cld_ff;
    status_word[IWC_ST_DAD]             = dad_ff;
    status_word[IWC_ST_CNT+3:IWC_ST_CNT] = cnt_ff;
  end

endmodule

// file: iwc_bus_model.sv
// Open-drain two-wire bus master model with pull-ups on both lines
`timescale 1ns/100ps
module iwc_bus_model (
  // Device enables, high while the device pulls a line low
  input  wire logic scl_oe,
  input  wire logic sda_oe,
  // Resolved line levels
  output logic      scl_line,
  output logic      sda_line
);
  logic scl_drv = 1'h1;
  logic sda_drv = 1'h1;
  int   falls   = 0;
  // Released lines float high through the pull-ups
  assign scl_line = scl_drv & ~scl_oe;
  assign sda_line = sda_drv & ~sda_oe;
  // Start: data falls while the clock is high
  task automatic start_c();
    #13 falls = 0;
    sda_drv = 1'h0;
    #160;
  endtask
  // Clock pulses; a clock held low by the device stretches the low phase
  task automatic pulses(input int n);
    #13;
    repeat (n) begin
      if (!scl_drv) begin
        scl_drv = 1'h1;
        wait (scl_line === 1'h1);
        #173;
      end
      scl_drv = 1'h0;
      falls   = (falls == 9) ? 1 : falls + 1;
      #80 sda_drv = 1'h1;
      #80;
    end
  endtask
  // Stop: data rises while the clock is high
  task automatic stop_c();
    #13 sda_drv = 1'h0;
    #160 scl_drv = 1'h1;
    wait (scl_line === 1'h1);
    #173 sda_drv = 1'h1;
    #160;
  endtask
endmodule

// file: iwc_checker.sv
// Concurrent checks on the wait, acknowledge and interrupt ports
`timescale 1ns/100ps
module iwc_checker (
  // Clock and reset
  input wire logic        clk,
  input wire logic        rstn,
  // Register bus
  input wire logic        hsel,
  input wire logic [31:0] haddr,
  input wire logic [1:0]  htrans,
  input wire logic        hwrite,
  input wire logic [31:0] hwdata,
  input wire logic        hready,
  // Line enables and neighbour levels
  input wire logic        serial_clock_pin_oe,
  input wire logic        serial_data_pin_oe,
  input wire logic        tx_dir,
  input wire logic        addr_match,
  input wire logic        ext_code,
  input wire logic        restart_req,
  // System outputs
  input wire logic        irq_req,
  input wire logic        unit_enable
);
  logic       aw_ff;
  logic       nxt_aw;
  logic [7:0] ctl_ff;
  logic [7:0] nxt_ctl;
  logic       rel_w;
  // Shadow of control register writes
  always_comb begin
    nxt_aw  = aw_ff;
    nxt_ctl = ctl_ff;
    if (hready) nxt_aw = hsel && htrans[1] && hwrite && (haddr[7:0] == 8'h00);
    if (aw_ff && hready) nxt_ctl = hwdata[7:0];
  end
  always_ff @(posedge clk) begin
    aw_ff  <= rstn ? nxt_aw : 1'h0;
    ctl_ff <= rstn ? nxt_ctl : 8'h00;
  end
  assign rel_w = aw_ff && hready && hwdata[7] && hwdata[5];
  default clocking @(posedge clk); endclocking
  default disable iff (!rstn);
  // Reset, disable, wait, interrupt and acknowledge relations
  rst_vals_a: assert property (disable iff (1'h0) !rstn |=> !irq_req && !unit_enable)
    else $error("outputs active after reset");
  off_quiet_a: assert property (!unit_enable && !$past(unit_enable) |->
    !irq_req && !serial_clock_pin_oe) else $error("disabled unit acted");
  irq_pulse_a: assert property (irq_req |=> !irq_req) else $error("irq longer than one cycle");
  wait_irq_a: assert property ($rose(serial_clock_pin_oe) && !ext_code |-> irq_req)
    else $error("wait without interrupt");
  wait_on_a: assert property ($rose(serial_clock_pin_oe) |-> $past(unit_enable))
    else $error("wait while disabled");
  rel_drop_a: assert property (rel_w && serial_clock_pin_oe |-> ##[1:3] !serial_clock_pin_oe)
    else $error("release did not free clock");
  restart_drop_a: assert property (restart_req && unit_enable && serial_clock_pin_oe
    |-> ##[1:3] !serial_clock_pin_oe) else $error("restart did not free clock");
  hold_wait_a: assert property ($fell(serial_clock_pin_oe) |-> $past(rel_w) ||
    $past(rel_w, 2) || $past(restart_req) || $past(restart_req, 2) || !$past(unit_enable))
    else $error("wait ended on its own");
  ack_gate_a: assert property (serial_data_pin_oe && !tx_dir |-> ctl_ff[2] || addr_match)
    else $error("acknowledge while disabled");
endmodule

// file: iwc_top_bench.sv
// Self-checking bench for the wait, acknowledge and interrupt control
`timescale 1ns/100ps
`define CHK(a, e) begin check_count++; if ((a) !== (e)) begin bad_count++; \
  $display("ERROR t=%0t got %h exp %h", $time, a, e); end end
module iwc_top_bench;
  import iwc_pkg::*;
  logic        clk = 1'h0, rstn = 1'h0, hsel = 1'h0, hwrite = 1'h0;
  logic        rdy_n = 1'h1, rd_dp = 1'h0, tx_low = 1'h0, restart_req = 1'h0;
  logic        start_fail_evt = 1'h0;
  logic        role_master = 1'h1, addr_match = 1'h0, ext_code = 1'h0, tx_dir = 1'h0;
  logic [31:0] haddr = 32'h0, hwdata = 32'h0, lf = 32'hEAB2FD01;
  logic [1:0]  htrans = 2'h0;
  logic [31:0] hrdata, rd_q[$];
  logic        hreadyout, hresp, irq_req, unit_enable, scl_line, sda_line;
  logic        serial_clock_pin_oe, serial_data_pin_oe;
  int          irq_q[$], bad_count = 0, check_count = 0;
  iwc_top dut_u (.clk, .rstn, .hsel, .haddr, .htrans, .hwrite, .hsize(3'h2), .hwdata,
    .hready(hreadyout), .hrdata, .hreadyout, .hresp, .serial_clock_pin_in(scl_line),
    .serial_clock_pin_out(), .serial_clock_pin_oe, .serial_data_pin_in(sda_line),
    .serial_data_pin_out(), .serial_data_pin_oe, .role_master, .addr_match,
    .ext_code, .tx_dir, .tx_low, .restart_req, .start_fail_evt, .irq_req,
    .unit_enable);
  iwc_bus_model bm_u (.scl_oe(serial_clock_pin_oe), .sda_oe(serial_data_pin_oe),
    .scl_line, .sda_line);
  // Clock and random neighbour levels
  initial forever #20 clk = ~clk;
  function automatic logic [31:0] lfsr(input logic [31:0] s);
    return {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
  endfunction
  always @(posedge clk) begin
    lf             <= lfsr(lf);
    tx_low         <= lf[0];
    start_fail_evt <= lf[1] & lf[5];
  end
  always @(negedge clk) rdy_n <= hreadyout;
  // Bus master cycle, held until ready is sampled high
  task automatic ahb(input logic w, input logic [7:0] a, input logic [31:0] d);
    @(posedge clk);
    hsel   <= 1'h1;
    haddr  <= {24'h0, a};
    htrans <= 2'h2;
    hwrite <= w;
    do @(posedge clk); while (rdy_n !== 1'h1);
    hsel   <= 1'h0;
    htrans <= 2'h0;
    hwdata <= d;
    rd_dp  <= !w;
    do @(posedge clk); while (rdy_n !== 1'h1);
    rd_dp  <= 1'h0;
  endtask
  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    ahb(1'h1, a, d);
  endtask
  task automatic rd(input logic [7:0] a, input logic [31:0] e);
    rd_q.push_back(e);
    ahb(1'h0, a, 32'h0);
  endtask
  task automatic pins(input logic c, input logic s);
    repeat (5) @(posedge clk);
    #1;
    `CHK(serial_clock_pin_oe, c)
    `CHK(serial_data_pin_oe, s)
  endtask
  task automatic done(input string n);
    $display("test %s done", n);
  endtask
  task automatic close_out();
    `CHK(rd_q.size() + irq_q.size(), 0)
    $display("checks %0d mismatches %0d", check_count, bad_count);
    if (bad_count == 0 && check_count > 0) $display("ALL CHECKS OK");
    else $display("CHECKS NOT OK");
    $finish;
  endtask
  // Result watcher: samples mid-cycle, away from the launching edge
  always @(negedge clk) begin
    if (rd_dp && hreadyout) `CHK(hrdata, rd_q.pop_front())
    if (irq_req === 1'h1) begin
      if (irq_q.size() == 0) `CHK(1'h1, 1'h0)
      else `CHK(bm_u.falls, irq_q.pop_front())
    end
  end
  initial begin
    #300000;
    bad_count++;
    close_out();
  end
  // Main sequence
  initial begin
    repeat (12) @(posedge clk);
    rstn <= 1'h1;
    rd(IWC_OFF_CTRL, 32'h0);
    rd(8'h08, 32'h0);
    wr(IWC_OFF_STATUS, 32'hFFFF);
    rd(IWC_OFF_STATUS, 32'h0);
    done("reset");
    wr(IWC_OFF_CTRL, 32'h1C);
    bm_u.start_c();
    bm_u.pulses(9);
    pins(1'h0, 1'h0);
    bm_u.stop_c();
    done("disabled");
    wr(IWC_OFF_CTRL, 32'h90);
    bm_u.start_c();
    irq_q.push_back(9);
    bm_u.pulses(9);
    pins(1'h1, 1'h0);
    wr(IWC_OFF_CTRL, 32'hB0);
    pins(1'h0, 1'h0);
    rd(IWC_OFF_CTRL, 32'h90);
    irq_q.push_back(8);
    bm_u.pulses(8);
    pins(1'h1, 1'h0);
    restart_req <= 1'h1;
    @(posedge clk);
    restart_req <= 1'h0;
    pins(1'h0, 1'h0);
    bm_u.pulses(1);
    pins(1'h0, 1'h0);
    irq_q.push_back(9);
    bm_u.stop_c();
    wr(IWC_OFF_CTRL, 32'h0);
    rd(IWC_OFF_STATUS, 32'h0);
    done("wait at eighth");
    wr(IWC_OFF_CTRL, 32'h9C);
    bm_u.start_c();
    bm_u.pulses(8);
    pins(1'h0, 1'h0);
    irq_q.push_back(9);
    bm_u.pulses(1);
    pins(1'h1, 1'h0);
    wr(IWC_OFF_CTRL, 32'hBC);
    bm_u.pulses(8);
    pins(1'h0, 1'h1);
    irq_q.push_back(9);
    bm_u.pulses(1);
    pins(1'h1, 1'h0);
    wr(IWC_OFF_CTRL, 32'hBC);
    irq_q.push_back(9);
    bm_u.stop_c();
    wr(IWC_OFF_CTRL, 32'h0);
    rd(IWC_OFF_STATUS, 32'h0);
    done("wait at ninth");
    // Slave with own address: acks without ack enable, waits at ninth
    role_master <= 1'h0;
    addr_match  <= 1'h1;
    wr(IWC_OFF_CTRL, 32'h80);
    bm_u.start_c();
    bm_u.pulses(8);
    pins(1'h0, 1'h1);
    irq_q.push_back(9);
    bm_u.pulses(1);
    pins(1'h1, 1'h0);
    wr(IWC_OFF_CTRL, 32'hA0);
    pins(1'h0, 1'h0);
    bm_u.stop_c();
    pins(1'h0, 1'h0);
    wr(IWC_OFF_CTRL, 32'h0);
    // Slave that received an extension code waits at eighth
    addr_match <= 1'h0;
    ext_code   <= 1'h1;
    wr(IWC_OFF_CTRL, 32'h80);
    bm_u.start_c();
    bm_u.pulses(8);
    pins(1'h1, 1'h0);
    wr(IWC_OFF_CTRL, 32'hA0);
    irq_q.push_back(9);
    bm_u.pulses(1);
    pins(1'h0, 1'h0);
    bm_u.stop_c();
    wr(IWC_OFF_CTRL, 32'h0);
    rd(IWC_OFF_STATUS, 32'h0);
    done("slave");
    close_out();
  end
endmodule
bind iwc_top iwc_checker chk_u (.clk, .rstn, .hsel, .haddr, .htrans, .hwrite, .hwdata,
  .hready, .serial_clock_pin_oe, .serial_data_pin_oe, .tx_dir, .addr_match, .ext_code,
  .restart_req, .irq_req, .unit_enable);
